// >>> include/tsa_cfg.svh
// Constants for the transmit status and access control block.
// Assumes a 200 MHz core clock and a 32-bit register port.
`ifndef TSA_CFG_SVH
`define TSA_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TSA_OFS_STATUS 8'h28
`define TSA_OFS_NAC    8'h30
`define TSA_OFS_IEN    8'h38
`define TSA_OFS_ICLR   8'h3C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TSA_NFLAG    4
`define TSA_B_DONE   0
`define TSA_B_STOP   1
`define TSA_B_DUNA   2
`define TSA_B_JAB    3
`define TSA_B_AIS    15
`define TSA_B_NIS    16
`define TSA_B_SF     21
`define TSA_B_SQE    19
`define TSA_B_THR_HI 15
`define TSA_B_THR_LO 14
`define TSA_B_RUN    13
`define TSA_B_IOC    31
`define TSA_B_DJAB   14

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TSA_SF_RST   1'b0
`define TSA_SQE_RST  1'b1
`define TSA_THR_RST  2'h0
`define TSA_RUN_RST  1'b0
`define TSA_FLG_RST  4'h0

// ----------------------------------------------------------------
// Threshold table in bytes
// ----------------------------------------------------------------
`define TSA_THR100_0 11'h080
`define TSA_THR100_1 11'h100
`define TSA_THR100_2 11'h200
`define TSA_THR100_3 11'h400
`define TSA_THR10_0  11'h048
`define TSA_THR10_1  11'h060
`define TSA_THR10_2  11'h080
`define TSA_THR10_3  11'h0A0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TSA_CLK_NS   5
`define TSA_POLL_NS  1000
`define TSA_POLL_CYC ((`TSA_POLL_NS) / (`TSA_CLK_NS))

`endif

// >>> include/tsa_pkg.sv
// Types shared by the transmit status and access control block.
// Assumes nothing beyond a SystemVerilog compiler.
package tsa_pkg;
    // Transmit process state, one-hot
    typedef enum logic [2:0] {
        TSA_STOP = 3'h1,
        TSA_RUN  = 3'h2,
        TSA_SUSP = 3'h4
    } tsa_state_e;
    typedef logic [31:0] tsa_word_t;
    typedef logic [7:0]  tsa_addr_t;
endpackage

// >>> hdl/tsa_sticky_flags.sv
// Latch-high event flags, cleared by writing one.
// Assumes set and clear vectors are synchronous to core_clk.
`include "tsa_cfg.svh"

module tsa_sticky_flags (
    input  wire logic                    core_clk,
    input  wire logic                    reset,
    input  wire logic [`TSA_NFLAG-1:0]   setVec,
    input  wire logic [`TSA_NFLAG-1:0]   clrVec,
    output logic      [`TSA_NFLAG-1:0]   flags
);
    // ----------------------------------------------------------------
    // One flop per flag
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `TSA_NFLAG; i++) begin : g_flag
            logic flag_r;

            // Set beats clear so an event in the clearing cycle survives
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    flag_r <= 1'b0;
                end else if (setVec[i]) begin
                    flag_r <= 1'b1;
                end else if (clrVec[i]) begin
                    flag_r <= 1'b0;
                end
            end

            // Each generated flop owns one bit, so no bit has two writers
            assign flags[i] = flag_r;
        end
    endgenerate
endmodule // tsa_sticky_flags

// >>> hdl/tsa_threshold.sv
// FIFO transmit threshold lookup.
// Assumes the speed input is stable during frame transmission.
`include "tsa_cfg.svh"

module tsa_threshold (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [1:0]  thrField,
    input  wire logic        linkSpeed100,
    output logic      [10:0] thresholdBytes
);
    logic [10:0] thrNxt;

    // ----------------------------------------------------------------
    // Table select per speed
    // ----------------------------------------------------------------
    always_comb begin
        case ({linkSpeed100, thrField})
            3'h4:    thrNxt = `TSA_THR100_0;
            3'h5:    thrNxt = `TSA_THR100_1;
            3'h6:    thrNxt = `TSA_THR100_2;
            3'h7:    thrNxt = `TSA_THR100_3;
            3'h0:    thrNxt = `TSA_THR10_0;
            3'h1:    thrNxt = `TSA_THR10_1;
            3'h2:    thrNxt = `TSA_THR10_2;
            3'h3:    thrNxt = `TSA_THR10_3;
            default: thrNxt = `TSA_THR100_0;
        endcase
    end

    // Registered so the FIFO sees a clean level
    always_ff @(posedge core_clk) begin
        if (reset) begin
            thresholdBytes <= `TSA_THR10_0;
        end else begin
            thresholdBytes <= thrNxt;
        end
    end

    chk_thr_table: assert property (
        @(posedge core_clk) disable iff (reset)
        (linkSpeed100 && thrField == 2'h3) |=>
        thresholdBytes == `TSA_THR100_3)
        else $error("threshold table value wrong");
endmodule // tsa_threshold

// >>> hdl/tsa_tx_status.sv
// Transmit status flags, access control fields and process state.
// Assumes a transmit DMA engine drives the event pulses and obeys the
// run, suspend and threshold outputs; software uses the register port.
//
// Behaviour
// - Jabber expiry latches flag 3, stops the process and flags the descriptor.
// - A missing descriptor latches flag 2 and suspends the process.
// - Flag 1 latches while the process is stopped.
// - Flag 0 latches on frame completion only when the first descriptor asked.
// - Flags stay high once set and clear by writing a one to them.
// - Store-and-forward at bit 21 overrides the threshold, clear at reset.
// - Bit 19 resets high to disable the SQE test; clearing it enables it.
// - Bits 15 to 14 select the threshold from two speed tables.
// - Bit 13 starts the process on one and stops it on zero, reset zero.
// - Normal summary follows flags 0 and 2, abnormal follows 1 and 3.
`include "tsa_cfg.svh"

module tsa_tx_status (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrStrobe,
    input  wire logic        regRdStrobe,
    output logic      [31:0] regRdData,
    input  wire logic        jabberExpire,
    input  wire logic        descFetchFail,
    input  wire logic        frameDone,
    input  wire logic        frameIoc,
    input  wire logic        pollDemand,
    input  wire logic        autoPollEn,
    input  wire logic        linkSpeed100,
    output logic      [2:0]  txState,
    output logic             descJabberFlag,
    output logic             storeForward,
    output logic             sqeTestEnable,
    output logic             thresholdActive,
    output logic      [10:0] thresholdBytes,
    output logic             irq
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    tsa_pkg::tsa_state_e    state_r;
    tsa_pkg::tsa_state_e    state_nxt;
    logic                   runCtl_r;
    logic                   sf_r;
    logic                   sqeDis_r;
    logic [1:0]             thr_r;
    logic [`TSA_NFLAG-1:0]  irqEn_r;
    logic [`TSA_NFLAG-1:0]  flags;
    logic [`TSA_NFLAG-1:0]  setVec;
    logic [`TSA_NFLAG-1:0]  clrVec;
    logic                   normSum;
    logic                   abnSum;
    tsa_pkg::tsa_word_t     statusWord;
    tsa_pkg::tsa_word_t     nacWord;
    tsa_pkg::tsa_word_t     rdNxt;
    logic                   wrStatus;
    logic                   wrNac;
    logic                   wrIen;
    logic                   wrIclr;
    logic                   startReq;
    logic                   stopReq;
    logic [7:0]             pollCnt_r;
    logic                   pollTick;
    logic                   descJab_r;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Write strobes qualified by address
    assign wrStatus = regWrStrobe && regAddr == `TSA_OFS_STATUS;
    assign wrNac    = regWrStrobe && regAddr == `TSA_OFS_NAC;
    assign wrIen    = regWrStrobe && regAddr == `TSA_OFS_IEN;
    assign wrIclr   = regWrStrobe && regAddr == `TSA_OFS_ICLR;

    // Run bit written one starts, written zero stops
    assign startReq = wrNac && regWrData[`TSA_B_RUN];
    assign stopReq  = wrNac && !regWrData[`TSA_B_RUN];

    // ----------------------------------------------------------------
    // Access control register
    // ----------------------------------------------------------------
    // Run bit is always writable
    always_ff @(posedge core_clk) begin
        if (reset) begin
            runCtl_r <= `TSA_RUN_RST;
        end else if (wrNac) begin
            runCtl_r <= regWrData[`TSA_B_RUN];
        end
    end

    // Mode fields only change while stopped; a write mid-frame would
    // alter FIFO policy under a live transfer, so it is dropped
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sf_r     <= `TSA_SF_RST;
            sqeDis_r <= `TSA_SQE_RST;
            thr_r    <= `TSA_THR_RST;
        end else if (wrNac && state_r == tsa_pkg::TSA_STOP) begin
            sf_r     <= regWrData[`TSA_B_SF];
            sqeDis_r <= regWrData[`TSA_B_SQE];
            thr_r    <= regWrData[`TSA_B_THR_HI:`TSA_B_THR_LO];
        end
    end

    // Field outputs
    assign storeForward    = sf_r;
    assign thresholdActive = !sf_r;
    assign sqeTestEnable   = !sqeDis_r;

    // ----------------------------------------------------------------
    // Threshold lookup
    // ----------------------------------------------------------------
    tsa_threshold u_thr (
        .core_clk       (core_clk),
        .reset          (reset),
        .thrField       (thr_r),
        .linkSpeed100   (linkSpeed100),
        .thresholdBytes (thresholdBytes)
    );

    // ----------------------------------------------------------------
    // Auto poll divider
    // ----------------------------------------------------------------
    // Free-running enable; a suspended process retries on each tick
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pollCnt_r <= 8'h00;
        end else if (pollCnt_r == 8'(`TSA_POLL_CYC - 1)) begin
            pollCnt_r <= 8'h00;
        end else begin
            pollCnt_r <= pollCnt_r + 8'h01;
        end
    end

    assign pollTick = autoPollEn && pollCnt_r == 8'(`TSA_POLL_CYC - 1);

    // ----------------------------------------------------------------
    // Transmit process state
    // ----------------------------------------------------------------
    // Jabber outranks everything; stop request next; then progress
    always_comb begin
        state_nxt = state_r;
        if (jabberExpire) begin
            state_nxt = tsa_pkg::TSA_STOP;
        end else if (stopReq) begin
            state_nxt = tsa_pkg::TSA_STOP;
        end else begin
            case (state_r)
                tsa_pkg::TSA_STOP: begin
                    if (startReq) begin
                        state_nxt = tsa_pkg::TSA_RUN;
                    end
                end
                tsa_pkg::TSA_RUN: begin
                    if (descFetchFail) begin
                        state_nxt = tsa_pkg::TSA_SUSP;
                    end
                end
                tsa_pkg::TSA_SUSP: begin
                    // Software has handed a descriptor back by now
                    if (pollDemand || pollTick) begin
                        state_nxt = tsa_pkg::TSA_RUN;
                    end
                end
                default: state_nxt = tsa_pkg::TSA_STOP;
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_r <= tsa_pkg::TSA_STOP;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign txState = state_r;

    // ----------------------------------------------------------------
    // Descriptor jabber mark
    // ----------------------------------------------------------------
    // One-cycle pulse: the DMA sets its descriptor status bit from it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            descJab_r <= 1'b0;
        end else begin
            descJab_r <= jabberExpire;
        end
    end

    assign descJabberFlag = descJab_r;

    // ----------------------------------------------------------------
    // Event flags
    // ----------------------------------------------------------------
    // Set sources per flag
    always_comb begin
        setVec = `TSA_FLG_RST;
        setVec[`TSA_B_DONE] = frameDone && frameIoc;
        setVec[`TSA_B_STOP] = state_r == tsa_pkg::TSA_STOP;
        setVec[`TSA_B_DUNA] = descFetchFail &&
                              state_r == tsa_pkg::TSA_RUN;
        setVec[`TSA_B_JAB]  = jabberExpire;
    end

    // Either the status word or the clear register clears by ones
    always_comb begin
        clrVec = `TSA_FLG_RST;
        if (wrStatus || wrIclr) begin
            clrVec = regWrData[`TSA_NFLAG-1:0];
        end
    end

    tsa_sticky_flags u_flags (
        .core_clk (core_clk),
        .reset    (reset),
        .setVec   (setVec),
        .clrVec   (clrVec),
        .flags    (flags)
    );

    // Summaries are live views of the latched flags
    assign normSum = flags[`TSA_B_DONE] || flags[`TSA_B_DUNA];
    assign abnSum  = flags[`TSA_B_STOP] || flags[`TSA_B_JAB];

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    // Enable register uses the flag layout
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irqEn_r <= `TSA_FLG_RST;
        end else if (wrIen) begin
            irqEn_r <= regWrData[`TSA_NFLAG-1:0];
        end
    end

    // Level output, drops as soon as the flag is cleared
    assign irq = |(flags & irqEn_r);

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Word images; reserved bits stay zero
    always_comb begin
        statusWord = '0;
        statusWord[`TSA_NFLAG-1:0] = flags;
        statusWord[`TSA_B_AIS]     = abnSum;
        statusWord[`TSA_B_NIS]     = normSum;
        nacWord = '0;
        nacWord[`TSA_B_SF]  = sf_r;
        nacWord[`TSA_B_SQE] = sqeDis_r;
        nacWord[`TSA_B_THR_HI:`TSA_B_THR_LO] = thr_r;
        nacWord[`TSA_B_RUN] = runCtl_r;
    end

    // Mux; the clear register is write-only and reads zero
    always_comb begin
        rdNxt = '0;
        case (regAddr)
            `TSA_OFS_STATUS: rdNxt = statusWord;
            `TSA_OFS_NAC:    rdNxt = nacWord;
            `TSA_OFS_IEN:    rdNxt[`TSA_NFLAG-1:0] = irqEn_r;
            default:         rdNxt = '0;
        endcase
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            regRdData <= '0;
        end else if (regRdStrobe) begin
            regRdData <= rdNxt;
        end else begin
            regRdData <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_jabber_stop: assert property (
        @(posedge core_clk) disable iff (reset)
        jabberExpire |=> state_r == tsa_pkg::TSA_STOP
                         && flags[`TSA_B_JAB] && descJabberFlag)
        else $error("jabber did not stop and flag");

    chk_unavail_susp: assert property (
        @(posedge core_clk) disable iff (reset)
        (state_r == tsa_pkg::TSA_RUN && descFetchFail && !jabberExpire
         && !stopReq)
        |=> state_r == tsa_pkg::TSA_SUSP && flags[`TSA_B_DUNA])
        else $error("missing descriptor did not suspend");

    chk_stop_flag: assert property (
        @(posedge core_clk) disable iff (reset)
        state_r == tsa_pkg::TSA_STOP |=> flags[`TSA_B_STOP])
        else $error("stopped flag not held");

    chk_done_cause: assert property (
        @(posedge core_clk) disable iff (reset)
        $rose(flags[`TSA_B_DONE]) |-> $past(frameDone && frameIoc))
        else $error("done flag without requesting descriptor");

    chk_w1c_clear: assert property (
        @(posedge core_clk) disable iff (reset)
        (wrStatus && regWrData[`TSA_B_JAB] && !jabberExpire)
        |=> !flags[`TSA_B_JAB])
        else $error("write one did not clear flag");

    chk_zero_keeps: assert property (
        @(posedge core_clk) disable iff (reset)
        (flags[`TSA_B_DONE] && wrStatus && !regWrData[`TSA_B_DONE])
        |=> flags[`TSA_B_DONE])
        else $error("write zero changed a flag");

    chk_sf_override: assert property (
        @(posedge core_clk) disable iff (reset)
        (wrNac && state_r == tsa_pkg::TSA_STOP && regWrData[`TSA_B_SF])
        |=> storeForward && !thresholdActive)
        else $error("store and forward not applied");

    chk_sqe_reset: assert property (
        @(posedge core_clk) disable iff (reset)
        $past(reset) |-> !sqeTestEnable && !storeForward)
        else $error("mode field reset value wrong");

    chk_run_stop: assert property (
        @(posedge core_clk) disable iff (reset)
        stopReq |=> state_r == tsa_pkg::TSA_STOP ##1 flags[`TSA_B_STOP])
        else $error("run bit zero did not stop");

    chk_abn_summary: assert property (
        @(posedge core_clk) disable iff (reset)
        jabberExpire |=> statusWord[`TSA_B_AIS])
        else $error("abnormal summary missing");

    chk_guard_fields: assert property (
        @(posedge core_clk) disable iff (reset)
        (wrNac && state_r != tsa_pkg::TSA_STOP) |=> $stable(thr_r))
        else $error("mode field changed while running");
endmodule // tsa_tx_status

// >>> verif/tsa_host_model.sv
// Stand-in for the transmit DMA and host driver side of the block.
// Assumes the bench raises evReq for one cycle per wanted event.
module tsa_host_model (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [4:0] evReq,
    output logic            jabberExpire,
    output logic            descFetchFail,
    output logic            frameDone,
    output logic            frameIoc,
    output logic            pollDemand
);
    timeunit 1ns;
    timeprecision 100ps;

    // --------------------------------------------------------------
    // Event pulses
    // --------------------------------------------------------------
    // Registered so each pulse is a whole cycle, never a glitch
    always_ff @(posedge core_clk) begin
        if (reset) begin
            {pollDemand, frameIoc, frameDone} <= 3'h0;
            {descFetchFail, jabberExpire} <= 2'h0;
        end else begin
            jabberExpire  <= evReq[0];
            descFetchFail <= evReq[1];
            frameDone     <= evReq[2];
            frameIoc      <= evReq[3]; // Level with frameDone
            pollDemand    <= evReq[4]; // Sent after the hand-over
        end
    end
endmodule // tsa_host_model

// >>> verif/tsa_tx_status_tb.sv
// Self-checking bench for the transmit status and access block.
// Assumes the register port answers one cycle after a read strobe.
module tsa_tx_status_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // --------------------------------------------------------------
    // Signals and model state
    // --------------------------------------------------------------
    logic        core_clk, reset, regWrStrobe, regRdStrobe;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData;
    logic        jabberExpire, descFetchFail, frameDone, frameIoc;
    logic        pollDemand, autoPollEn, linkSpeed100;
    logic [2:0]  txState;
    logic        descJabberFlag, storeForward, sqeTestEnable;
    logic        thresholdActive, irq;
    logic [10:0] thresholdBytes;
    logic [4:0]  evReq;
    int          fail_count, check_count, seed, cyc;
    logic [31:0] mNac, d;
    int          t100[4] = '{128, 256, 512, 1024};
    int          t10[4]  = '{72, 96, 128, 160};

    tsa_tx_status tsa_tx_status_inst (
        .core_clk(core_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .jabberExpire(jabberExpire), .descFetchFail(descFetchFail),
        .frameDone(frameDone), .frameIoc(frameIoc),
        .pollDemand(pollDemand), .autoPollEn(autoPollEn),
        .linkSpeed100(linkSpeed100), .txState(txState),
        .descJabberFlag(descJabberFlag), .storeForward(storeForward),
        .sqeTestEnable(sqeTestEnable),
        .thresholdActive(thresholdActive),
        .thresholdBytes(thresholdBytes), .irq(irq)
    );
    tsa_host_model tsa_host_model_inst (
        .core_clk(core_clk), .reset(reset), .evReq(evReq),
        .jabberExpire(jabberExpire), .descFetchFail(descFetchFail),
        .frameDone(frameDone), .frameIoc(frameIoc),
        .pollDemand(pollDemand)
    );

    // Free-running 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Hang guard, far above the expected run length
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fail_count++;
            conclude();
        end
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Status image: flags plus both summary bits
    function automatic logic [31:0] stat(input int f);
        return f | ((f & 5) ? 32'h10000 : 0) | ((f & 10) ? 32'h8000 : 0);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        regWrStrobe <= 1'b1;
        regAddr     <= a;
        regWrData   <= v;
        @(posedge core_clk);
        regWrStrobe <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regRdStrobe <= 1'b1;
        regAddr     <= a;
        @(posedge core_clk);
        regRdStrobe <= 1'b0;
        #1 chk(regRdData, exp);
    endtask

    // One event request; returns once the design has taken it
    task automatic ev(input logic [4:0] v);
        @(posedge core_clk);
        evReq <= v;
        @(posedge core_clk);
        evReq <= 5'h0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        {reset, regWrStrobe, regRdStrobe, autoPollEn} = 4'h8;
        {regAddr, regWrData, evReq, linkSpeed100} = 0;
        {fail_count, check_count, cyc} = 0;
        seed = 57099;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        rd(8'h30, 32'h00080000);
        rd(8'h28, stat(2));
        wr(8'h28, 32'h0);
        rd(8'h28, stat(2));
        wr(8'h28, 32'h2);
        rd(8'h28, stat(2));
        rd(8'h10, 32'h0);
        // Mode fields while stopped, with random reserved bits
        for (int i = 0; i < 8; i++) begin
            d = ($random(seed) & 32'hFFFF1FFF) | ((i % 4) << 14);
            wr(8'h30, d);
            mNac = d & 32'h0028C000;
            rd(8'h30, mNac);
            chk(storeForward, mNac[21]);
            chk(thresholdActive, !mNac[21]);
            chk(sqeTestEnable, !mNac[19]);
            for (int s = 0; s < 2; s++) begin
                @(posedge core_clk);
                linkSpeed100 <= s[0];
                repeat (2) @(posedge core_clk);
                #1 chk(thresholdBytes, s ? t100[i % 4] : t10[i % 4]);
            end
        end
        wr(8'h38, 32'h0);
        chk(irq, 1'b0);
        wr(8'h38, 32'hF);
        chk(irq, 1'b1);
        // Start, then clear the stop flag through the clear register
        wr(8'h30, mNac | 32'h2000);
        mNac = mNac | 32'h2000;
        chk(txState, tsa_pkg::TSA_RUN);
        wr(8'h3C, 32'h2);
        rd(8'h28, stat(0));
        chk(irq, 1'b0);
        wr(8'h30, (~mNac & 32'h0028C000) | 32'h2000);
        rd(8'h30, mNac);
        ev(5'h02);
        chk(txState, tsa_pkg::TSA_SUSP);
        rd(8'h28, stat(4));
        ev(5'h10);
        chk(txState, tsa_pkg::TSA_RUN);
        ev(5'h04);
        rd(8'h28, stat(4));
        ev(5'h0C);
        rd(8'h28, stat(5));
        chk(irq, 1'b1);
        // Clear one flag at a time; a zero bit must leave its flag set
        wr(8'h28, 32'h4);
        rd(8'h28, stat(1));
        wr(8'h28, 32'h1);
        rd(8'h28, stat(0));
        // Automatic polling resumes a suspended process by itself
        @(posedge core_clk);
        autoPollEn <= 1'b1;
        ev(5'h02);
        repeat (205) @(posedge core_clk);
        #1 chk(txState, tsa_pkg::TSA_RUN);
        wr(8'h28, 32'h4);
        ev(5'h01);
        chk(txState, tsa_pkg::TSA_STOP);
        chk(descJabberFlag, 1'b1);
        @(posedge core_clk);
        #1 chk(descJabberFlag, 1'b0);
        rd(8'h28, stat(10));
        // Reset after the jabber stop must bring every field back to its reset value
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rd(8'h30, 32'h00080000);
        rd(8'h28, stat(2));
        chk(txState, tsa_pkg::TSA_STOP);
        chk(irq, 1'b0);
        chk(descJabberFlag, 1'b0);
        conclude();
    end
endmodule // tsa_tx_status_tb
